/* core/rsm_reset_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none

module rsm_reset_sequencer
  import rsm_pkg::*;
#(
  parameter int unsigned PLL_STARTUP_CYCLES = PLL_STARTUP_CYC
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire rsm_apb_req_t apbReq,
  output rsm_apb_rsp_t      apbRsp,
  input  wire logic         rstPinIn,
  output logic              rstPinOut,
  output logic              rstPinOe,
  input  wire logic         lvdBelow,
  input  wire logic         avdBelow,
  input  wire logic         pllLocked,
  input  wire logic         wdgUnderflow,
  input  wire logic         illegalOpcode,
  input  wire logic         cpuIMask,
  input  wire logic         irqAck,
  input  wire logic         waitMode,
  input  wire logic         haltMode,
  output logic              coreReset_n,
  output logic              clockRelease,
  output logic              vectorFetch,
  output logic [15:0]       fetchAddr,
  output logic              avdIrq,
  output logic              wakeFromWait,
  output logic [9:0]        rcTrim,
  output logic [1:0]        lvdThreshold,
  output logic              lvdEnable,
  output logic              pllEnable
);

  rsm_phase_t  phase;
  rsm_cause_t  cause;
  logic [16:0] count;
  logic        pinSync1, pinSync2, lvdSync1, lvdSync2;
  logic        avdSync1, avdSync2, pllSync1, pllSync2;
  logic        extLatch, oeDly1, oeDly2;
  logic        lvdLow, extLow, seqReset;
  logic [7:0]  options, trimHigh;
  logic [1:0]  trimLow;
  logic        watchdog_reset_cause_flag, uvRf, warnFlag, warnIe, warnPend, lockedFlag;
  logic        apbAccess, integrityRead, warnRise;
  logic [7:0]  integrityReg;

  function automatic logic [16:0] delayLength(input logic [1:0] src);
    return (src == CLK_CRYSTAL) ? DELAY_LONG : DELAY_SHORT;
  endfunction : delayLength

  function automatic logic addrHit(input logic [31:0] a, input logic [7:0] o);
    return (a[31:8] == 24'h000000) && (a[7:0] == o);
  endfunction : addrHit

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      lvdSync1 <= 1'b0;
      lvdSync2 <= 1'b0;
      avdSync1 <= 1'b0;
      avdSync2 <= 1'b0;
      pllSync1 <= 1'b0;
      pllSync2 <= 1'b0;
    end else begin
      pinSync1 <= rstPinIn;
      pinSync2 <= pinSync1;
      lvdSync1 <= lvdBelow;
      lvdSync2 <= lvdSync1;
      avdSync1 <= avdBelow;
      avdSync2 <= avdSync1;
      pllSync1 <= pllLocked;
      pllSync2 <= pllSync1;
    end
  end

  // Tracks our own drive so a pin we hold low is not read as external.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oeDly1 <= 1'b1;
      oeDly2 <= 1'b1;
    end else begin
      oeDly1 <= rstPinOe;
      oeDly2 <= oeDly1;
    end
  end

  always_ff @(posedge clk or negedge reset_n or negedge rstPinIn) begin
    if (!rstPinIn) begin
      extLatch <= 1'b1;
    end else if (!reset_n) begin
      extLatch <= 1'b1;
    end else if (pinSync2 || phase != PH_RUN) begin
      // Outside run the latch only mirrors the pin, low from our drive or an external pull.
      extLatch <= 1'b0;
    end
  end

  assign lvdEnable    = options[OPT_LVD_EN];
  assign lvdThreshold = options[OPT_THR +: 2];
  assign pllEnable    = options[OPT_PLL_EN];
  assign lvdLow = lvdEnable && lvdSync2;
  assign extLow = !pinSync2 && !oeDly2;
  assign seqReset = (phase == PH_ACTIVE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_ACTIVE;
      cause <= CAUSE_EXT;
      count <= 17'd0;
    end else if (lvdLow) begin
      phase <= PH_ACTIVE;
      cause <= CAUSE_LVD;
      count <= 17'd0;
    end else begin
      unique case (phase)
        PH_RUN: begin
          count <= 17'd0;
          if (wdgUnderflow || illegalOpcode) begin
            phase <= PH_ACTIVE;
            cause <= wdgUnderflow ? CAUSE_WDG : CAUSE_ILLEGAL;
          end else if (extLow) begin
            phase <= PH_ACTIVE;
            cause <= CAUSE_EXT;
          end
        end
        PH_ACTIVE: begin
          count <= count + 17'd1;
          if ((cause == CAUSE_EXT && pinSync2) || cause == CAUSE_LVD ||
              ((cause == CAUSE_WDG || cause == CAUSE_ILLEGAL) &&
               count >= 17'(WDG_PULSE_CYC - 1))) begin
            if (pllEnable) begin
              phase <= PH_PLL;
              count <= 17'(PLL_STARTUP_CYCLES);
            end else begin
              phase <= PH_DELAY;
              count <= delayLength(options[OPT_CLK_SRC +: 2]);
            end
          end
        end
        PH_PLL: begin
          count <= count - 17'd1;
          if (count <= 17'd1) begin
            phase <= PH_DELAY;
            count <= delayLength(options[OPT_CLK_SRC +: 2]);
          end
        end
        PH_DELAY: begin
          count <= count - 17'd1;
          if (count <= 17'd1) begin
            phase <= PH_FETCH;
            count <= FETCH_CYCLES;
          end
        end
        PH_FETCH: begin
          count <= count - 17'd1;
          if (count <= 17'd1) begin
            phase <= PH_RUN;
          end
        end
        default: begin
          phase <= PH_ACTIVE;
          cause <= CAUSE_EXT;
          count <= 17'd0;
        end
      endcase
    end
  end

  assign rstPinOe = lvdLow || phase == PH_DELAY || phase == PH_PLL ||
                    (phase == PH_ACTIVE && cause != CAUSE_EXT);
  assign rstPinOut = 1'b0;

  assign coreReset_n  = phase == PH_FETCH || (phase == PH_RUN && !extLatch);
  assign clockRelease = (phase != PH_PLL);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchAddr   <= RESET_VECTOR_LO;
      vectorFetch <= 1'b0;
    end else begin
      vectorFetch <= (phase == PH_DELAY && count <= 17'd1 && !lvdLow) ||
                     (phase == PH_FETCH && count == FETCH_CYCLES);
      if (phase == PH_FETCH && count == FETCH_CYCLES) begin
        fetchAddr <= RESET_VECTOR_HI;
      end else begin
        fetchAddr <= RESET_VECTOR_LO;
      end
    end
  end

  assign apbAccess = apbReq.psel && apbReq.penable;
  assign integrityRead = apbAccess && !apbReq.pwrite &&
                         addrHit(apbReq.paddr, ADDR_INTEGRITY);

  // Trim fields and warnIe return to defaults on every device reset; options only on reset_n.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trimHigh <= TRIM_HIGH_RESET;
      trimLow  <= TRIM_LOW_RESET;
      warnIe   <= 1'b0;
      options  <= OPTIONS_RESET;
    end else if (seqReset) begin
      trimHigh <= TRIM_HIGH_RESET;
      trimLow  <= TRIM_LOW_RESET;
      warnIe   <= 1'b0;
    end else if (apbAccess && apbReq.pwrite && !haltMode) begin
      if (addrHit(apbReq.paddr, ADDR_INTEGRITY)) begin
        trimLow <= apbReq.pwdata[BIT_TRIM_LO +: 2];
        warnIe  <= apbReq.pwdata[BIT_WARN_IE];
      end
      if (addrHit(apbReq.paddr, ADDR_TRIM_HIGH)) begin
        trimHigh <= apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, ADDR_OPTIONS)) begin
        options <= apbReq.pwdata[7:0];
      end
    end
  end
  assign rcTrim = {trimHigh, trimLow};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reset_cause_flag <= 1'b0;
    end else if (phase == PH_RUN && wdgUnderflow && !lvdLow) begin
      watchdog_reset_cause_flag <= 1'b1;
    end else if (integrityRead || lvdLow) begin
      watchdog_reset_cause_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uvRf <= 1'b0;
    end else if (lvdLow) begin
      uvRf <= 1'b1;
    end else if (integrityRead) begin
      uvRf <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warnFlag   <= 1'b0;
      lockedFlag <= 1'b0;
    end else if (!haltMode) begin
      warnFlag   <= lvdEnable && avdSync2;
      lockedFlag <= pllEnable && pllSync2;
    end
  end

  assign warnRise = lvdEnable && avdSync2 && !warnFlag && !haltMode;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warnPend <= 1'b0;
    end else if (seqReset || !lvdEnable) begin
      warnPend <= 1'b0;
    end else if (warnRise && warnIe) begin
      warnPend <= 1'b1;
    end else if (irqAck) begin
      warnPend <= 1'b0;
    end
  end

  assign avdIrq = warnPend && warnIe && lvdEnable && !cpuIMask && !haltMode;
  assign wakeFromWait = avdIrq && waitMode;

  assign integrityReg = {1'b0, trimLow, watchdog_reset_cause_flag, lockedFlag, uvRf,
                         warnFlag, warnIe};

  always_comb begin
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = 1'b0;
    apbRsp.prdata  = 32'h00000000;
    if (addrHit(apbReq.paddr, ADDR_INTEGRITY)) begin
      apbRsp.prdata[7:0] = integrityReg;
    end else if (addrHit(apbReq.paddr, ADDR_TRIM_HIGH)) begin
      apbRsp.prdata[7:0] = trimHigh;
    end else if (addrHit(apbReq.paddr, ADDR_OPTIONS)) begin
      apbRsp.prdata[7:0] = options;
    end else if (addrHit(apbReq.paddr, ADDR_SEQ_STAT)) begin
      apbRsp.prdata[7:0] = {3'h0, cause, phase};
    end else begin
      apbRsp.pslverr = apbReq.psel && apbReq.penable;
    end
  end

  // Cycle counter for the delay phase, read only by assertions.
  logic [16:0] delaySeen;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delaySeen <= 17'd0;
    end else if (phase == PH_DELAY) begin
      delaySeen <= delaySeen + 17'd1;
    end else begin
      delaySeen <= 17'd0;
    end
  end

  a_delay_pin_low: assert property (
    @(posedge clk) disable iff (!reset_n)
    phase == PH_DELAY |-> rstPinOe && !rstPinOut)
    else $error("Reset pin released during delay.");

  a_delay_length: assert property (
    @(posedge clk) disable iff (!reset_n)
    (phase == PH_DELAY && $past(phase) == PH_DELAY && !lvdLow) ##1
    (phase == PH_FETCH) |->
    $past(delaySeen) == delayLength(options[OPT_CLK_SRC +: 2]) - 17'd1)
    else $error("Delay phase length wrong.");

  a_fetch_two: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(phase == PH_FETCH) |=>
    (phase == PH_FETCH ##1 phase == PH_RUN) or phase == PH_ACTIVE)
    else $error("Vector fetch not two cycles.");

  a_vector_order: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(phase == PH_FETCH) && !lvdLow |=>
    vectorFetch && fetchAddr == RESET_VECTOR_HI)
    else $error("Vector high byte not fetched.");

  a_lvd_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    lvdLow |=> rstPinOe && phase == PH_ACTIVE)
    else $error("Undervoltage did not hold pin.");

  a_wdg_drive: assert property (
    @(posedge clk) disable iff (!reset_n)
    phase == PH_RUN && wdgUnderflow && !lvdLow |=>
    rstPinOe [*8] ##1 rstPinOe)
    else $error("Watchdog pulse too short.");

  a_irq_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    avdIrq |-> warnIe && !cpuIMask && !haltMode && lvdEnable)
    else $error("Warning irq without enable.");

  a_uv_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    uvRf && !integrityRead |=> uvRf)
    else $error("Undervoltage flag lost.");

  a_halt_freeze: assert property (
    @(posedge clk) disable iff (!reset_n)
    haltMode && $past(haltMode) |-> $stable(warnFlag) && !avdIrq)
    else $error("Register changed in halt.");

  a_ack_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    irqAck && !(warnRise && warnIe) |=> !warnPend)
    else $error("Pending irq survived service.");

  c_wdg_reset: cover property (@(posedge clk) disable iff (!reset_n)
    phase == PH_RUN && wdgUnderflow ##[1:300] phase == PH_DELAY);
  c_ext_reset: cover property (@(posedge clk) disable iff (!reset_n)
    phase == PH_ACTIVE && cause == CAUSE_EXT ##1 phase == PH_DELAY);
  c_warn_irq: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(avdIrq) && waitMode);
  c_pll_wait: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(phase == PH_PLL));

endmodule : rsm_reset_sequencer

`default_nettype wire

/* core/rsm_pkg.sv */
package rsm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // APB map, byte addresses.
  localparam logic [7:0] ADDR_INTEGRITY = 8'h00;
  localparam logic [7:0] ADDR_TRIM_HIGH = 8'h04;
  localparam logic [7:0] ADDR_OPTIONS   = 8'h08;
  localparam logic [7:0] ADDR_SEQ_STAT  = 8'h0c;

  // Integrity control/status field positions.
  localparam int unsigned BIT_TRIM_LO  = 5;
  localparam int unsigned BIT_WDG_RF   = 4;
  localparam int unsigned BIT_LOCKED   = 3;
  localparam int unsigned BIT_UV_RF    = 2;
  localparam int unsigned BIT_WARN_F   = 1;
  localparam int unsigned BIT_WARN_IE  = 0;

  // Option register field positions.
  localparam int unsigned OPT_LVD_EN  = 0;
  localparam int unsigned OPT_THR     = 1;
  localparam int unsigned OPT_CLK_SRC = 3;
  localparam int unsigned OPT_PLL_EN  = 5;

  localparam logic [7:0] TRIM_HIGH_RESET = 8'hff;
  localparam logic [1:0] TRIM_LOW_RESET  = 2'h0;
  localparam logic [7:0] OPTIONS_RESET   = 8'h01;

  localparam logic [15:0] RESET_VECTOR_LO = 16'hfffe;
  localparam logic [15:0] RESET_VECTOR_HI = 16'hffff;

  localparam logic [16:0] DELAY_SHORT  = 17'd256;
  localparam logic [16:0] DELAY_LONG   = 17'd4096;
  localparam logic [16:0] FETCH_CYCLES = 17'd2;

  // Least watchdog output pulse width and PLL start-up time.
  localparam int unsigned WDG_PULSE_NS   = 200;
  localparam int unsigned WDG_PULSE_CYC  =
    (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_STARTUP_US = 500;
  localparam int unsigned PLL_STARTUP_CYC =
    (PLL_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CLK_RC      = 2'h0,
    CLK_EXTERN  = 2'h1,
    CLK_CRYSTAL = 2'h2
  } rsm_clk_src_t;

  typedef enum logic [1:0] {
    CAUSE_EXT     = 2'h0,
    CAUSE_LVD     = 2'h1,
    CAUSE_WDG     = 2'h2,
    CAUSE_ILLEGAL = 2'h3
  } rsm_cause_t;

  typedef enum logic [2:0] {
    PH_ACTIVE = 3'b000,
    PH_PLL    = 3'b001,
    PH_DELAY  = 3'b011,
    PH_FETCH  = 3'b010,
    PH_RUN    = 3'b110
  } rsm_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } rsm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rsm_apb_rsp_t;

endpackage : rsm_pkg

/* tb/rsm_pin_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module rsm_pin_partner (
  input  wire logic rstPinOe,
  input  wire logic extPull,
  output logic      rstPinIn
);
  // The weak pull-up lifts the line whenever nobody pulls it down.
  // shared pin
  assign rstPinIn = (rstPinOe || extPull) ? 1'b0 : 1'b1;
endmodule : rsm_pin_partner

`default_nettype wire

/* tb/reset_sequencer_supply_monitor_test.sv */
`timescale 1ns/100ps
`default_nettype none

module reset_sequencer_supply_monitor_test
  import rsm_pkg::*;
;
  logic         clk;
  logic         reset_n;
  rsm_apb_req_t apbReq;
  rsm_apb_rsp_t apbRsp;
  logic         rstPinIn;
  logic         rstPinOe;
  logic         extPull;
  logic         lvdBelow;
  logic         avdBelow;
  logic         pllLocked;
  logic         wdgUnderflow;
  logic         illegalOpcode;
  logic         cpuIMask;
  logic         irqAck;
  logic         waitMode;
  logic         haltMode;
  logic         coreReset_n;
  logic         clockRelease;
  logic         vectorFetch;
  logic [15:0]  fetchAddr;
  logic         avdIrq;
  logic         wakeFromWait;
  logic [9:0]   rcTrim;
  logic [1:0]   lvdThr;
  logic         lvdEn;
  logic         pllEn;
  logic [31:0]  rdData;
  logic         rdErr;
  int           nErrors;
  int           checkCount;

  rsm_reset_sequencer #(.PLL_STARTUP_CYCLES(20)) i_rsm_reset_sequencer (
    .clk(clk), .reset_n(reset_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .rstPinIn(rstPinIn), .rstPinOut(), .rstPinOe(rstPinOe),
    .lvdBelow(lvdBelow), .avdBelow(avdBelow), .pllLocked(pllLocked),
    .wdgUnderflow(wdgUnderflow), .illegalOpcode(illegalOpcode),
    .cpuIMask(cpuIMask), .irqAck(irqAck), .waitMode(waitMode),
    .haltMode(haltMode), .coreReset_n(coreReset_n),
    .clockRelease(clockRelease), .vectorFetch(vectorFetch),
    .fetchAddr(fetchAddr), .avdIrq(avdIrq), .wakeFromWait(wakeFromWait),
    .rcTrim(rcTrim), .lvdThreshold(lvdThr), .lvdEnable(lvdEn),
    .pllEnable(pllEn)
  );

  rsm_pin_partner i_rsm_pin_partner (
    .rstPinOe(rstPinOe), .extPull(extPull), .rstPinIn(rstPinIn)
  );

  always #4 clk = ~clk;

  task conclude();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      nErrors++;
    end
  endtask : chk

  // Holds the whole request until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= wr;
    apbReq.paddr <= {24'h0, a};
    apbReq.pwdata <= wd;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      nErrors++;
      conclude();
    end
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task rd(input string name, input logic [7:0] a, input logic [7:0] m,
          input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, {24'h0, exp}, rdData & {24'h0, m});
  endtask : rd

  // Measures one reset sequence; a negative delay skips that count.
  task run_seq(input int expDelay, input int expHold);
    int i;
    int oe;
    int hold;
    int fc;
    logic [15:0] fa0;
    logic [15:0] fa1;
    oe = 0;
    hold = 0;
    fc = 0;
    fa0 = 16'h0;
    fa1 = 16'h0;
    for (i = 0; i < 6000; i++) begin
      #1;
      if (rstPinOe === 1'b1 && coreReset_n === 1'b0) oe++;
      if (clockRelease === 1'b0) hold++;
      if (vectorFetch === 1'b1) begin
        if (fc == 0) fa0 = fetchAddr;
        else fa1 = fetchAddr;
        fc++;
      end
      if (coreReset_n === 1'b1 && fc > 0 && vectorFetch === 1'b0) break;
      @(posedge clk);
    end
    if (i == 6000) begin
      nErrors++;
      conclude();
    end
    if (expDelay >= 0) chk("pin low cycles", expDelay, oe);
    chk("clock hold", expHold, hold);
    chk("fetch cycles", 32'd2, fc);
    chk("fetch first", {16'h0, RESET_VECTOR_LO}, {16'h0, fa0});
    chk("fetch second", {16'h0, RESET_VECTOR_HI}, {16'h0, fa1});
  endtask : run_seq

  task pin_pulse();
    @(posedge clk);
    extPull <= 1'b1;
    #1;
    chk("async core reset", 32'h0, {31'h0, coreReset_n});
    repeat (10) @(posedge clk);
    extPull <= 1'b0;
  endtask : pin_pulse

  task wdg_pulse();
    @(posedge clk);
    wdgUnderflow <= 1'b1;
    @(posedge clk);
    wdgUnderflow <= 1'b0;
  endtask : wdg_pulse

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    apbReq = '0;
    {extPull, lvdBelow, avdBelow, pllLocked, wdgUnderflow} = '0;
    {illegalOpcode, irqAck, waitMode, haltMode} = '0;
    cpuIMask = 1'b1;
    nErrors = 0;
    checkCount = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    run_seq(256, 0);
    rd("trim high", ADDR_TRIM_HIGH, 8'hff, TRIM_HIGH_RESET);
    rd("options", ADDR_OPTIONS, 8'hff, OPTIONS_RESET);
    rd("integrity", ADDR_INTEGRITY, 8'he9, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rdErr});
    $display("test power-on done");
    wdg_pulse();
    run_seq(WDG_PULSE_CYC + 256, 0);
    rd("watchdog flag", ADDR_INTEGRITY, 8'h14, 8'h10);
    rd("flag read clear", ADDR_INTEGRITY, 8'h14, 8'h00);
    $display("test watchdog done");
    pin_pulse();
    run_seq(256, 0);
    rd("ext no flag", ADDR_INTEGRITY, 8'h14, 8'h00);
    apb(1'b1, ADDR_OPTIONS, 32'h11);
    pin_pulse();
    run_seq(4096, 0);
    $display("test pin done");
    apb(1'b1, ADDR_OPTIONS, 32'h21);
    @(posedge clk);
    illegalOpcode <= 1'b1;
    @(posedge clk);
    illegalOpcode <= 1'b0;
    run_seq(-1, 20);
    apb(1'b1, ADDR_OPTIONS, 32'h01);
    $display("test illegal done");
    @(posedge clk);
    lvdBelow <= 1'b1;
    // The detector input crosses two synchroniser stages first.
    repeat (2) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1;
      chk("held low", 32'h1, {31'h0, rstPinOe});
    end
    lvdBelow <= 1'b0;
    run_seq(-1, 0);
    wdg_pulse();
    run_seq(WDG_PULSE_CYC + 256, 0);
    rd("both flags", ADDR_INTEGRITY, 8'h14, 8'h14);
    rd("undervolt flag", ADDR_INTEGRITY, 8'h14, 8'h00);
    apb(1'b1, ADDR_OPTIONS, 32'h01);
    $display("test undervoltage done");
    pllLocked <= 1'b1;
    apb(1'b1, ADDR_OPTIONS, 32'h21);
    rd("locked", ADDR_INTEGRITY, 8'h08, 8'h08);
    chk("option outputs", 32'h3, {29'h0, lvdThr, lvdEn, pllEn});
    pllLocked <= 1'b0;
    apb(1'b1, ADDR_INTEGRITY, 32'h01);
    avdBelow <= 1'b1;
    repeat (5) @(posedge clk);
    rd("warn flag", ADDR_INTEGRITY, 8'h03, 8'h03);
    chk("masked irq", 32'h0, {31'h0, avdIrq});
    cpuIMask <= 1'b0;
    waitMode <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq", 32'h1, {31'h0, avdIrq});
    chk("wake", 32'h1, {31'h0, wakeFromWait});
    irqAck <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    #1;
    chk("irq cleared", 32'h0, {31'h0, avdIrq});
    apb(1'b1, ADDR_OPTIONS, 32'h20);
    rd("warn gated", ADDR_INTEGRITY, 8'h02, 8'h00);
    waitMode <= 1'b0;
    avdBelow <= 1'b0;
    $display("test warning done");
    haltMode <= 1'b1;
    apb(1'b1, ADDR_TRIM_HIGH, 32'h55);
    rd("halt frozen", ADDR_TRIM_HIGH, 8'hff, 8'hff);
    haltMode <= 1'b0;
    apb(1'b1, ADDR_TRIM_HIGH, 32'h55);
    apb(1'b1, ADDR_INTEGRITY, 32'h60);
    @(posedge clk);
    #1;
    chk("trim", 32'h157, {22'h0, rcTrim});
    $display("test trim done");
    conclude();
  end
endmodule : reset_sequencer_supply_monitor_test

`default_nettype wire
